// ==== iam_cfg.svh ====
`ifndef IAM_CFG_SVH
`define IAM_CFG_SVH

// Channel count, one per input letter A and B
`define IAM_NCH 2

// Register byte addresses on the APB side
`define IAM_A_CTRL 8'h00
`define IAM_A_KWORD 8'h04
`define IAM_A_ARG 8'h08
`define IAM_A_CMD 8'h0c
`define IAM_A_VALUE 8'h10
`define IAM_A_TXT0 8'h14
`define IAM_A_TXT1 8'h18
`define IAM_A_TXTLEN 8'h1c
`define IAM_A_IRQ_STAT 8'h20
`define IAM_A_IRQ_MASK 8'h24
`define IAM_A_ALARM 8'h28
`define IAM_A_MIN0 8'h2c
`define IAM_A_MIN1 8'h30

// Field positions
`define IAM_CTRL_STCLR 0
`define IAM_CMD_QRY 0
`define IAM_CMD_CHAN 1
`define IAM_CMD_CHAIN 2
`define IAM_CMD_YES 3
`define IAM_IRQ_ERR 2

// Reset values
`define IAM_RST_SP 32'h0000_0000
`define IAM_RST_MASK 3'h0

// Hysteresis of 0.25 in Q16.16 display units
`define IAM_HYST_Q 33'h0_0000_4000

// Answer text buffer depth in characters
`define IAM_TXT_DEPTH 8

// Full four-character keyword forms, first character in the top byte
`define IAM_KW_HIGH_S 32'h4849_4748
`define IAM_KW_LOWE_S 32'h4c4f_5745
`define IAM_KW_HIEN_S 32'h4849_454e
`define IAM_KW_LOEN_S 32'h4c4f_454e
`define IAM_KW_FAUL_S 32'h4641_554c
`define IAM_KW_AUDI_S 32'h4155_4449
`define IAM_KW_ALAR_S 32'h414c_4152
`define IAM_KW_MINI_S 32'h4d49_4e49

// Answer characters
`define IAM_TX_SF 16'h5346
`define IAM_TX_HI 16'h4849
`define IAM_TX_LO 16'h4c4f
`define IAM_TX_NONE 16'h2d2d
`define IAM_TX_YES 24'h594553
`define IAM_TX_NO 16'h4e4f
`define IAM_TX_SEMI 8'h3b
`define IAM_TX_HASH 8'h23
`define IAM_TX_SPACE 8'h20

`endif

// ==== iam_pkg.sv ====
package iam_pkg;

    // Alarm flags of one channel
    typedef struct packed {
        logic fault;
        logic hi;
        logic lo;
    } iam_alarm_t;

    // Filtered measurement of one channel
    typedef struct packed {
        logic valid;
        logic fault;
        logic [31:0] temp;
    } iam_meas_t;

    // Decoded command keyword
    typedef enum logic [3:0] {
        IAM_KW_NONE = 4'h0,
        IAM_KW_HIGH = 4'h1,
        IAM_KW_LOW = 4'h2,
        IAM_KW_HIEN = 4'h3,
        IAM_KW_LOEN = 4'h4,
        IAM_KW_FAULT = 4'h5,
        IAM_KW_AUDIO = 4'h6,
        IAM_KW_ALARM = 4'h7,
        IAM_KW_MIN = 4'h8
    } iam_kw_t;

endpackage

// ==== iam_f2q.sv ====
// Single-precision value to signed Q16.16, saturating
module iam_f2q (
    input wire logic [31:0] f,
    output logic signed [31:0] q
);
    logic [23:0] mant; // Mantissa with hidden one
    logic signed [9:0] sh; // Left shift into Q16.16
    logic [31:0] mag; // Magnitude

    ////////////////////////////////////////////////////////////////////
    // Shift mantissa by biased exponent
    always_comb begin
        mant = {1'b1, f[22:0]};
        sh = $signed({2'b00, f[30:23]}) - 10'sd134;
        mag = 32'h0000_0000;
        if (f[30:23] == 8'h00) begin
            mag = 32'h0000_0000; // Zero and tiny values
        end else if (sh >= 10'sd8) begin
            mag = 32'h7fff_ffff; // Saturate
        end else if (sh >= 10'sd0) begin
            mag = {8'h00, mant} << sh[2:0];
        end else if (sh > -10'sd24) begin
            mag = {8'h00, mant} >> 5'(-sh);
        end
        q = f[31] ? -$signed(mag) : $signed(mag);
    end
endmodule

// ==== iam_monitor.sv ====
`include "iam_cfg.svh"

// Contract
// R1: Status answer is --, SF, HI or LO.
// R2: 0.25 hysteresis before high or low clears.
// R3: Alarms test the filtered temperature only.
// R4: High alarm when above high setpoint, enabled.
// R5: Low alarm when below low setpoint, enabled.
// R6: Setpoints kept and reported in display units.
// R7: Host sends setpoints within twenty characters.
// R8: Setpoints stored and returned as single precision.
// R9: High enable exchanged as YES or NO.
// R10: Low enable exchanged as YES or NO.
// R11: Fault enable YES/NO gates fault alarm.
// R12: Disabled alarm never asserts.
// R13: Buzzer sounds for alarm on audible channel.
// R14: Chained answers kept in order, semicolon separated.
// R15: Four-char keywords; three if fourth vowel.
// R16: Track per-channel minimum since statistics clear.
// R17: Host names channel by index or letter. The code takes only the index, in command bit 1.
// R18: Sensor fault code wins over high/low.
module iam_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire iam_pkg::iam_meas_t [1:0] meas,
    output wire iam_pkg::iam_alarm_t [1:0] alarm_flags,
    output logic buzzer,
    output logic irq
);
    import iam_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Declarations
    logic [31:0] kword_r; // Keyword text
    logic [31:0] arg_r; // Setpoint argument bits
    logic [31:0] value_r; // Numeric answer
    logic [31:0] hi_sp_r [`IAM_NCH]; // High setpoints
    logic [31:0] lo_sp_r [`IAM_NCH]; // Low setpoints
    logic [`IAM_NCH-1:0] hi_en_r; // High enables
    logic [`IAM_NCH-1:0] lo_en_r; // Low enables
    logic [`IAM_NCH-1:0] f_en_r; // Fault enables
    logic [`IAM_NCH-1:0] au_en_r; // Audible enables
    iam_alarm_t alm_r [`IAM_NCH]; // Alarm state
    logic [31:0] min_f_r [`IAM_NCH]; // Minimum as float
    logic signed [31:0] min_q_r [`IAM_NCH]; // Minimum as fixed
    logic [`IAM_NCH-1:0] min_v_r; // Minimum holds a sample
    logic [15:0] code [`IAM_NCH]; // Status code per channel
    logic [`IAM_NCH-1:0] ev_alm; // Alarm assert events
    logic [`IAM_NCH-1:0] any_alm; // Any alarm per channel
    logic [7:0] txt_r [`IAM_TXT_DEPTH]; // Answer text
    logic [3:0] len_r; // Text length
    logic [2:0] stat_r; // Sticky interrupt status
    logic [2:0] mask_r; // Interrupt mask
    logic wr; // Write access phase
    logic wr_cmd; // Command execution
    logic stats_clr; // Statistics clear pulse
    logic mapped; // Address decodes
    logic [31:0] rd_mux; // Read data
    iam_kw_t kw; // Decoded keyword
    logic ch; // Command channel
    logic [31:0] ans; // Answer chars, first on top
    logic [2:0] ans_n; // Answer length
    logic cmd_bad; // Rejected command
    logic yn_q; // Answer is YES/NO
    logic yn_v; // Value of that answer

    ////////////////////////////////////////////////////////////////////
    // Bus strobes
    assign pready = ce;
    assign wr = ce && psel && penable && pwrite;
    assign wr_cmd = wr && (paddr == `IAM_A_CMD);
    assign stats_clr = wr && (paddr == `IAM_A_CTRL) && pwdata[`IAM_CTRL_STCLR];
    assign pslverr = psel && penable && !mapped;
    assign ch = pwdata[`IAM_CMD_CHAN];

    ////////////////////////////////////////////////////////////////////
    // Keyword match with optional three-letter form
    function automatic logic kw_hit(input logic [31:0] w, input logic [31:0] full);
        logic vowel;
        vowel = (full[7:0] == 8'h41) || (full[7:0] == 8'h45) || (full[7:0] == 8'h49)
            || (full[7:0] == 8'h4f) || (full[7:0] == 8'h55);
        kw_hit = (w == full) || (vowel && (w[31:8] == full[31:8])
            && ((w[7:0] == `IAM_TX_SPACE) || (w[7:0] == 8'h00)));
    endfunction

    // Keyword decode
    always_comb begin
        kw = IAM_KW_NONE;
        if (kw_hit(kword_r, `IAM_KW_HIGH_S)) kw = IAM_KW_HIGH; // R15
        if (kw_hit(kword_r, `IAM_KW_LOWE_S)) kw = IAM_KW_LOW; // R15
        if (kw_hit(kword_r, `IAM_KW_HIEN_S)) kw = IAM_KW_HIEN;
        if (kw_hit(kword_r, `IAM_KW_LOEN_S)) kw = IAM_KW_LOEN;
        if (kw_hit(kword_r, `IAM_KW_FAUL_S)) kw = IAM_KW_FAULT;
        if (kw_hit(kword_r, `IAM_KW_AUDI_S)) kw = IAM_KW_AUDIO;
        if (kw_hit(kword_r, `IAM_KW_ALAR_S)) kw = IAM_KW_ALARM;
        if (kw_hit(kword_r, `IAM_KW_MINI_S)) kw = IAM_KW_MIN;
    end

    ////////////////////////////////////////////////////////////////////
    // Answer text of the command being executed
    always_comb begin
        ans = 32'h0000_0000;
        ans_n = 3'd0;
        cmd_bad = 1'b0;
        yn_q = 1'b0;
        yn_v = 1'b0;
        if (pwdata[`IAM_CMD_QRY]) begin
            case (kw)
                // Numeric answers leave a marker in the text
                IAM_KW_HIGH, IAM_KW_LOW, IAM_KW_MIN: begin
                    ans = {`IAM_TX_HASH, 24'h00_0000};
                    ans_n = 3'd1;
                end
                IAM_KW_HIEN: begin
                    yn_q = 1'b1;
                    yn_v = hi_en_r[ch]; // R9
                end
                IAM_KW_LOEN: begin
                    yn_q = 1'b1;
                    yn_v = lo_en_r[ch]; // R10
                end
                IAM_KW_FAULT: begin
                    yn_q = 1'b1;
                    yn_v = f_en_r[ch]; // R11
                end
                IAM_KW_AUDIO: begin
                    yn_q = 1'b1;
                    yn_v = au_en_r[ch];
                end
                IAM_KW_ALARM: begin
                    ans = {code[ch], 16'h0000}; // R1
                    ans_n = 3'd2;
                end
                default: begin
                    cmd_bad = 1'b1; // Unknown keyword
                end
            endcase
        end else begin
            case (kw)
                IAM_KW_HIGH, IAM_KW_LOW, IAM_KW_HIEN, IAM_KW_LOEN, IAM_KW_FAULT,
                IAM_KW_AUDIO: begin
                    cmd_bad = 1'b0;
                end
                default: begin
                    cmd_bad = 1'b1; // Unknown or query-only keyword
                end
            endcase
        end
        if (yn_q) begin
            ans = yn_v ? {`IAM_TX_YES, 8'h00} : {`IAM_TX_NO, 16'h0000}; // R9 R10 R11
            ans_n = yn_v ? 3'd3 : 3'd2;
        end
        // Separator before a chained answer
        if (pwdata[`IAM_CMD_CHAIN] && (ans_n != 3'd0)) begin
            ans = {`IAM_TX_SEMI, ans[31:8]}; // R14
            ans_n = ans_n + 3'd1;
        end
        // No room left in the text buffer
        if ((len_r + {1'b0, ans_n}) > 4'(`IAM_TXT_DEPTH)) begin
            cmd_bad = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Keyword and argument registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            kword_r <= 32'h0000_0000;
            arg_r <= `IAM_RST_SP;
        end else if (wr) begin
            if (paddr == `IAM_A_KWORD) kword_r <= pwdata;
            if (paddr == `IAM_A_ARG) arg_r <= pwdata; // R7
        end
    end

    // Setpoints and enables, written by commands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < `IAM_NCH; i++) begin
                hi_sp_r[i] <= `IAM_RST_SP;
                lo_sp_r[i] <= `IAM_RST_SP;
            end
            hi_en_r <= '0;
            lo_en_r <= '0;
            f_en_r <= '0;
            au_en_r <= '0;
        end else if (wr_cmd && !cmd_bad && !pwdata[`IAM_CMD_QRY]) begin
            case (kw)
                IAM_KW_HIGH: hi_sp_r[ch] <= arg_r; // R6 R8
                IAM_KW_LOW: lo_sp_r[ch] <= arg_r; // R6 R8
                IAM_KW_HIEN: hi_en_r[ch] <= pwdata[`IAM_CMD_YES]; // R9
                IAM_KW_LOEN: lo_en_r[ch] <= pwdata[`IAM_CMD_YES]; // R10
                IAM_KW_FAULT: f_en_r[ch] <= pwdata[`IAM_CMD_YES]; // R11
                IAM_KW_AUDIO: au_en_r[ch] <= pwdata[`IAM_CMD_YES];
                default: begin
                end
            endcase
        end
    end

    // Numeric query answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_r <= 32'h0000_0000;
        end else if (wr_cmd && !cmd_bad && pwdata[`IAM_CMD_QRY]) begin
            case (kw)
                IAM_KW_HIGH: value_r <= hi_sp_r[ch]; // R6 R8
                IAM_KW_LOW: value_r <= lo_sp_r[ch]; // R6 R8
                IAM_KW_MIN: value_r <= min_f_r[ch]; // R16
                default: begin
                end
            endcase
        end
    end

    // Answer text buffer, appended in command order
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < `IAM_TXT_DEPTH; i++) begin
                txt_r[i] <= 8'h00;
            end
            len_r <= 4'h0;
        end else if (wr && (paddr == `IAM_A_TXTLEN)) begin
            len_r <= 4'h0; // Host consumed the text
        end else if (wr_cmd && !cmd_bad) begin
            for (int i = 0; i < 4; i++) begin
                if (3'(i) < ans_n) begin
                    txt_r[3'(len_r + 4'(i))] <= ans[31 - 8 * i -: 8]; // R14
                end
            end
            len_r <= len_r + {1'b0, ans_n};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Per-channel alarm and statistics logic
    genvar c;
    generate
        for (c = 0; c < `IAM_NCH; c++) begin : g_ch
            logic signed [31:0] tq; // Filtered temperature
            logic signed [31:0] hq; // High setpoint
            logic signed [31:0] lq; // Low setpoint
            logic signed [32:0] tx; // Widened copies
            logic signed [32:0] hx;
            logic signed [32:0] lx;
            iam_alarm_t nxt; // Next alarm state

            iam_f2q u_tq (.f(meas[c].temp), .q(tq));
            iam_f2q u_hq (.f(hi_sp_r[c]), .q(hq));
            iam_f2q u_lq (.f(lo_sp_r[c]), .q(lq));

            assign tx = {tq[31], tq};
            assign hx = {hq[31], hq};
            assign lx = {lq[31], lq};

            // Alarm decision on each filtered sample
            always_comb begin
                nxt = alm_r[c];
                nxt.fault = f_en_r[c] && meas[c].fault; // R11 R12
                if (!hi_en_r[c]) begin
                    nxt.hi = 1'b0; // R12
                end else if (meas[c].valid && (tq > hq)) begin
                    nxt.hi = 1'b1; // R3 R4
                end else if (meas[c].valid && (tx < hx - $signed(`IAM_HYST_Q))) begin
                    nxt.hi = 1'b0; // R2
                end
                if (!lo_en_r[c]) begin
                    nxt.lo = 1'b0; // R12
                end else if (meas[c].valid && (tq < lq)) begin
                    nxt.lo = 1'b1; // R3 R5
                end else if (meas[c].valid && (tx > lx + $signed(`IAM_HYST_Q))) begin
                    nxt.lo = 1'b0; // R2
                end
            end

            // Alarm state register
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    alm_r[c] <= '0;
                end else if (ce) begin
                    alm_r[c] <= nxt;
                end
            end

            // Fault wins over high, high over low
            assign code[c] = alm_r[c].fault ? `IAM_TX_SF : // R18
                alm_r[c].hi ? `IAM_TX_HI : alm_r[c].lo ? `IAM_TX_LO : `IAM_TX_NONE; // R1
            assign any_alm[c] = |alm_r[c];
            assign ev_alm[c] = ce && (|nxt) && !any_alm[c];
            assign alarm_flags[c] = alm_r[c];

            // Running minimum, restarted by statistics clear
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    min_f_r[c] <= 32'h0000_0000;
                    min_q_r[c] <= 32'sh0000_0000;
                    min_v_r[c] <= 1'b0;
                end else if (ce) begin
                    if (meas[c].valid && (stats_clr || !min_v_r[c] || (tq < min_q_r[c]))) begin
                        min_f_r[c] <= meas[c].temp; // R16
                        min_q_r[c] <= tq;
                        min_v_r[c] <= 1'b1;
                    end else if (stats_clr) begin
                        min_v_r[c] <= 1'b0; // R16
                    end
                end
            end

            a_hi_gate: assert property ( // R12
                @(posedge pclk) disable iff (!presetn)
                (ce && !hi_en_r[c]) |=> !alm_r[c].hi)
                else $error("high alarm set while disabled");

            a_hi_set: assert property ( // R4
                @(posedge pclk) disable iff (!presetn)
                (ce && meas[c].valid && hi_en_r[c] && (tq > hq)) |=> alm_r[c].hi)
                else $error("high alarm not set above setpoint");

            a_hi_hyst: assert property ( // R2
                @(posedge pclk) disable iff (!presetn)
                (ce && hi_en_r[c] && alm_r[c].hi && meas[c].valid
                    && (tx >= hx - $signed(`IAM_HYST_Q))) |=> alm_r[c].hi)
                else $error("high alarm dropped inside hysteresis");

            a_lo_set: assert property ( // R5
                @(posedge pclk) disable iff (!presetn)
                (ce && meas[c].valid && lo_en_r[c] && (tq < lq)) ##1 lo_en_r[c]
                    |-> alm_r[c].lo)
                else $error("low alarm not set below setpoint");

            a_fault_code: assert property ( // R18
                @(posedge pclk) disable iff (!presetn)
                alm_r[c].fault |-> (code[c] == `IAM_TX_SF))
                else $error("fault code not reported first");

            a_min_track: assert property ( // R16
                @(posedge pclk) disable iff (!presetn)
                (ce && meas[c].valid && min_v_r[c] && (tq < min_q_r[c]))
                    |=> (min_f_r[c] == $past(meas[c].temp)))
                else $error("minimum not updated by lower sample");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Buzzer from any alarm on an audible channel
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buzzer <= 1'b0;
        end else if (ce) begin
            buzzer <= |(any_alm & au_en_r); // R13
        end
    end

    // Sticky status, set wins over write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_r <= 3'h0;
            mask_r <= `IAM_RST_MASK;
        end else if (ce) begin
            stat_r <= (stat_r & ~((wr && (paddr == `IAM_A_IRQ_STAT)) ? pwdata[2:0] : 3'h0))
                | {wr_cmd && cmd_bad, ev_alm};
            if (wr && (paddr == `IAM_A_IRQ_MASK)) mask_r <= pwdata[2:0];
        end
    end

    // Level interrupt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= |(stat_r & mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read decode
    always_comb begin
        rd_mux = 32'h0000_0000;
        mapped = 1'b1;
        case (paddr)
            `IAM_A_CTRL: rd_mux = 32'h0000_0000;
            `IAM_A_KWORD: rd_mux = kword_r;
            `IAM_A_ARG: rd_mux = arg_r;
            `IAM_A_CMD: rd_mux = 32'h0000_0000;
            `IAM_A_VALUE: rd_mux = value_r;
            `IAM_A_TXT0: rd_mux = {txt_r[0], txt_r[1], txt_r[2], txt_r[3]};
            `IAM_A_TXT1: rd_mux = {txt_r[4], txt_r[5], txt_r[6], txt_r[7]};
            `IAM_A_TXTLEN: rd_mux = {28'h000_0000, len_r};
            `IAM_A_IRQ_STAT: rd_mux = {29'h0000_0000, stat_r};
            `IAM_A_IRQ_MASK: rd_mux = {29'h0000_0000, mask_r};
            `IAM_A_ALARM: rd_mux = {25'h000_0000, buzzer, alm_r[1], alm_r[0]};
            `IAM_A_MIN0: rd_mux = min_f_r[0];
            `IAM_A_MIN1: rd_mux = min_f_r[1];
            default: mapped = 1'b0;
        endcase
    end

    // Read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (ce && psel && !penable) begin
            prdata <= rd_mux;
        end
    end

    a_kw_short: assert property ( // R15
        @(posedge pclk) disable iff (!presetn)
        (kword_r == 32'h4155_4420) |-> (kw == IAM_KW_AUDIO))
        else $error("three-letter keyword not accepted");

    a_txt_grow: assert property ( // R14
        @(posedge pclk) disable iff (!presetn)
        (wr_cmd && !cmd_bad) |=> (len_r == 4'($past(len_r) + {1'b0, $past(ans_n)})))
        else $error("answer text not appended");

    a_sp_store: assert property ( // R8
        @(posedge pclk) disable iff (!presetn)
        (wr_cmd && !cmd_bad && !pwdata[`IAM_CMD_QRY] && (kw == IAM_KW_HIGH))
            |=> (hi_sp_r[$past(ch)] == $past(arg_r)))
        else $error("high setpoint not stored");

    a_buzz_on: assert property ( // R13
        @(posedge pclk) disable iff (!presetn)
        (ce && any_alm[0] && au_en_r[0]) |=> buzzer)
        else $error("buzzer silent on audible alarm");
endmodule

// ==== iam_host.sv ====
////////////////////////////////////////////////////////////////
// Remote host model: issues commands as APB transfers
module iam_host (
    input wire logic pclk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    timeunit 1ns;
    timeprecision 1ps;
    int tmo = 0; // Count of transfers that never completed
    // Idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end
    // One transfer, held until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) tmo++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// ==== input_alarm_monitor_tb_top.sv ====
`include "iam_cfg.svh"
////////////////////////////////////////////////////////////////
module input_alarm_monitor_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import iam_pkg::*;
    // Command row: clear text, keyword, argument, command, text, length
    typedef struct packed {
        logic clr;
        logic [31:0] kw;
        logic [31:0] arg;
        logic [3:0] cmd;
        logic [31:0] t0;
        logic [7:0] len;
    } iam_row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, buzzer, irq, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, t0, ln;
    iam_meas_t [1:0] meas = '0;
    iam_alarm_t [1:0] alarm_flags;
    int errors = 0;
    int compares = 0;
    iam_row_t rows [12] = '{
        '{1'b1, `IAM_KW_HIGH_S, 32'h42c8_0000, 4'h0, 32'h0, 8'h0},
        '{1'b1, `IAM_KW_HIEN_S, 32'h0, 4'h8, 32'h0, 8'h0},
        '{1'b1, `IAM_KW_HIEN_S, 32'h0, 4'h1, 32'h5945_5300, 8'h3},
        '{1'b1, `IAM_KW_LOEN_S, 32'h0, 4'h1, 32'h4e4f_0000, 8'h2},
        '{1'b0, `IAM_KW_FAUL_S, 32'h0, 4'h5, 32'h4e4f_3b4e, 8'h5},
        '{1'b1, `IAM_KW_ALAR_S, 32'h0, 4'h1, 32'h2d2d_0000, 8'h2},
        '{1'b1, `IAM_KW_HIEN_S, 32'h0, 4'h3, 32'h4e4f_0000, 8'h2},
        '{1'b1, 32'h4155_4420, 32'h0, 4'h8, 32'h0, 8'h0},
        '{1'b1, 32'h4c4f_5720, 32'h4120_0000, 4'h0, 32'h0, 8'h0},
        '{1'b1, `IAM_KW_LOEN_S, 32'h0, 4'h8, 32'h0, 8'h0},
        '{1'b1, `IAM_KW_HIGH_S, 32'h0, 4'h1, 32'h2300_0000, 8'h1},
        '{1'b1, 32'h4849_4520, 32'h0, 4'h1, 32'h0, 8'h0}};
    iam_monitor u_iam_monitor (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas(meas),
        .alarm_flags(alarm_flags), .buzzer(buzzer), .irq(irq));
    iam_host u_iam_host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    // Clock of 10 ns
    initial begin
        forever #5 pclk = ~pclk;
    end
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_iam_host.xfer(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a);
        u_iam_host.xfer(1'b0, a, 32'h0, q, e);
    endtask
    // Issue one command, then fetch the answer text and its length
    task automatic cmd(input logic clr, input logic [31:0] kw, input logic [31:0] arg,
                       input logic [3:0] c);
        if (clr) wr(`IAM_A_TXTLEN, 32'h0);
        wr(`IAM_A_KWORD, kw);
        wr(`IAM_A_ARG, arg);
        wr(`IAM_A_CMD, {28'h0, c});
        rd(`IAM_A_TXT0);
        t0 = q;
        rd(`IAM_A_TXTLEN);
        ln = q;
    endtask
    // One filtered sample, then wait out the flag and buzzer lag
    task automatic smp(input logic [31:0] t, input logic f);
        @(posedge pclk);
        meas[0] <= '{1'b1, f, t};
        @(posedge pclk);
        meas[0].valid <= 1'b0;
        repeat (2) @(posedge pclk);
        #1;
    endtask
    task automatic settle();
        repeat (2) @(posedge pclk);
        #1;
    endtask
    task automatic test_done();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Watchdogs: stalled transfer or overall run limit
    always @(posedge pclk) begin
        if (u_iam_host.tmo != 0) begin
            errors++;
            test_done();
        end
    end
    initial begin
        repeat (100000) @(posedge pclk);
        errors++;
        test_done();
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            cmd(rows[i].clr, rows[i].kw, rows[i].arg, rows[i].cmd);
            chk(t0 & ~(32'hffff_ffff >> (8 * rows[i].len)), rows[i].t0);
            chk(ln, {24'h0, rows[i].len});
        end
        rd(`IAM_A_VALUE);
        chk(q, 32'h42c8_0000);
        $display("command table done");
        smp(32'h42ca_0000, 1'b0);
        chk({29'h0, alarm_flags[0]}, 32'h2);
        chk({31'h0, buzzer}, 32'h1);
        cmd(1'b1, `IAM_KW_ALAR_S, 32'h0, 4'h1);
        chk(t0 & 32'hffff_0000, 32'h4849_0000);
        rd(`IAM_A_IRQ_STAT);
        chk(q & 32'h5, 32'h5);
        chk({31'h0, irq}, 32'h0);
        wr(`IAM_A_IRQ_MASK, 32'h1);
        settle();
        chk({31'h0, irq}, 32'h1);
        wr(`IAM_A_IRQ_STAT, 32'h1);
        settle();
        chk({31'h0, irq}, 32'h0);
        smp(32'h42c7_cccd, 1'b0);
        chk({29'h0, alarm_flags[0]}, 32'h2);
        smp(32'h42c7_0000, 1'b0);
        chk({29'h0, alarm_flags[0]}, 32'h0);
        smp(32'h42ca_0000, 1'b1);
        chk({29'h0, alarm_flags[0]}, 32'h2);
        cmd(1'b1, `IAM_KW_FAUL_S, 32'h0, 4'h8);
        settle();
        chk({29'h0, alarm_flags[0]}, 32'h6);
        cmd(1'b1, `IAM_KW_ALAR_S, 32'h0, 4'h1);
        chk(t0 & 32'hffff_0000, 32'h5346_0000);
        smp(32'h40a0_0000, 1'b0);
        chk({29'h0, alarm_flags[0]}, 32'h1);
        cmd(1'b1, `IAM_KW_HIEN_S, 32'h0, 4'h0);
        smp(32'h42ca_0000, 1'b0);
        chk({29'h0, alarm_flags[0]}, 32'h0);
        $display("alarm test done");
        wr(`IAM_A_CTRL, 32'h1);
        smp(32'h4248_0000, 1'b0);
        smp(32'h4270_0000, 1'b0);
        rd(`IAM_A_MIN0);
        chk(q, 32'h4248_0000);
        rd(8'h40);
        chk(q, 32'h0);
        chk({31'h0, e}, 32'h1);
        $display("minimum and bus test done");
        ce <= 1'b0;
        smp(32'h4220_0000, 1'b0);
        @(posedge pclk) ce <= 1'b1;
        rd(`IAM_A_MIN0);
        chk(q, 32'h4248_0000);
        $display("clock enable test done");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(`IAM_A_IRQ_MASK);
        chk(q, 32'h0);
        rd(`IAM_A_ALARM);
        chk(q, 32'h0);
        rd(`IAM_A_MIN0);
        chk(q, 32'h0);
        $display("reset test done");
        test_done();
    end
endmodule
